/* rtl/memtype_pkg.sv */
package memtype_pkg;

	// Memory type codes carried in bits 2..0 of every type field
	localparam logic [2:0] TYPE_UC = 3'h0;
	localparam logic [2:0] TYPE_WC = 3'h1;
	localparam logic [2:0] TYPE_WT = 3'h4;
	localparam logic [2:0] TYPE_WP = 3'h5;
	localparam logic [2:0] TYPE_WB = 3'h6;

	// Type field layout
	localparam int TYPE_LSB      = 0;
	localparam int TYPE_MSB      = 2;
	localparam int WRITE_MEM_BIT = 3;
	localparam int READ_MEM_BIT  = 4;
	localparam int FIELD_W       = 8;
	localparam int FIELDS_PER_REG = 8;

	// Register geometry
	localparam int REG_W           = 64;
	localparam int FIXED_REG_COUNT = 11;
	localparam logic [3:0] REG_64K_FIRST = 4'h0;
	localparam logic [3:0] REG_16K_FIRST = 4'h1;
	localparam logic [3:0] REG_4K_FIRST  = 4'h3;

	// Address segmentation of the lowest megabyte
	localparam int ONE_MEG_BIT   = 20;
	localparam int SEG_TOP_BIT   = 19;
	localparam int SEG_NEXT_BIT  = 18;
	localparam int SEG_64K_SHIFT = 16;
	localparam int SEG_16K_SHIFT = 14;
	localparam int SEG_4K_SHIFT  = 12;

	// Model-specific register indices of the fixed registers, consecutive from the base
	localparam logic [31:0] INDEX_FIXED_BASE   = 32'h0000_0100;
	localparam logic [31:0] INDEX_64K_BASE0    = 32'h0000_0100;
	localparam logic [31:0] INDEX_16K_BASE80   = 32'h0000_0101;
	localparam logic [31:0] INDEX_16K_BASEA0   = 32'h0000_0102;
	localparam logic [31:0] INDEX_4K_BASEC0    = 32'h0000_0103;
	localparam logic [31:0] INDEX_4K_BASEF8    = 32'h0000_010A;

	// Value after reset: every field uncacheable
	localparam logic [63:0] FIXED_RESET = 64'h0000_0000_0000_0000;
	localparam logic [63:0] READ_IDLE   = 64'h0000_0000_0000_0000;

endpackage

/* rtl/memtype_attr_decode.sv */
`timescale 1ns/1ps
module memtype_attr_decode (
	input  wire logic [7:0] FIELD,            // Raw 8-bit type field
	input  wire logic       EXT_ACTIVE,       // Extended encoding applies to this field
	input  wire logic       FORCE_UC,         // Typing mechanism off
	output logic      [2:0] MEM_TYPE,         // Resolved type code
	output logic            CACHEABLE,        // Lines may be cached
	output logic            WRITE_COMBINE,    // Writes may be merged
	output logic            SPECULATIVE,      // Speculative reads allowed
	output logic            READ_ALLOC,       // Read miss allocates
	output logic            WRITE_ALLOC,      // Write miss allocates
	output logic            WRITE_THROUGH,    // Write hit also updates memory
	output logic            HIT_INVALIDATE,   // Write hit invalidates line
	output logic            ALLOC_MODIFIED,   // Write miss allocates modified
	output logic            READ_TO_MEM,      // Reads go to memory
	output logic            WRITE_TO_MEM,     // Writes go to memory
	output logic            IO_RANGE          // Subrange routed as I/O
);

	wire logic [2:0] raw_type;
	wire logic       is_wc;
	wire logic       is_wt;
	wire logic       is_wp;
	wire logic       is_wb;

	// Only bits 2..0 pick the type; reserved bits never alter the decode
	assign raw_type = FORCE_UC ? memtype_pkg::TYPE_UC
		: FIELD[memtype_pkg::TYPE_MSB:memtype_pkg::TYPE_LSB];
	assign is_wc = raw_type == memtype_pkg::TYPE_WC;
	assign is_wt = raw_type == memtype_pkg::TYPE_WT;
	assign is_wp = raw_type == memtype_pkg::TYPE_WP;
	assign is_wb = raw_type == memtype_pkg::TYPE_WB;

	// Undefined codes fold to uncacheable, the safest reading of a bad field
	assign MEM_TYPE = (is_wc | is_wt | is_wp | is_wb) ? raw_type : memtype_pkg::TYPE_UC;

	// Uncacheable: no merging and no speculation at all
	assign WRITE_COMBINE = is_wc;
	assign SPECULATIVE   = is_wc | is_wt | is_wp | is_wb;
	assign CACHEABLE     = is_wt | is_wp | is_wb;

	// Allocation and write policy per type
	assign READ_ALLOC     = is_wt | is_wp | is_wb;
	assign WRITE_ALLOC    = is_wb;
	assign WRITE_THROUGH  = is_wt | is_wp;
	assign HIT_INVALIDATE = is_wp;
	assign ALLOC_MODIFIED = is_wb;

	// Memory routing bits exist only in the extended encoding; bits 7..5 ignored
	assign READ_TO_MEM  = ~EXT_ACTIVE | FIELD[memtype_pkg::READ_MEM_BIT];
	assign WRITE_TO_MEM = ~EXT_ACTIVE | FIELD[memtype_pkg::WRITE_MEM_BIT];
	assign IO_RANGE     = ~(READ_TO_MEM & WRITE_TO_MEM);

endmodule

/* rtl/fixed_range_memory_type_map.sv */
`timescale 1ns/1ps
// Operation
// - Standard field: bits 2..0 type, rest reserved
// - Extended field adds memory read/write routing bits
// - Extended encoding only for fixed-range fields
// - Standard decode unless extended encoding enabled
// - Uncacheable: no combining, no speculation
// - Write-combining: uncached, merged writes, speculative reads
// - Writethrough: read allocates, write hit updates both
// - Write-protect: writes to memory, hit invalidates
// - Writeback: write miss allocates modified
// - Mechanism disabled means everything uncacheable
// - Fixed ranges only below one megabyte
// - Uncovered address takes software default type
// - Registers 64 bits via model register access
// - Eight byte fields, lowest field lowest address
// - Extended field may mark an I/O subrange
// - Lowest 512K: one register, 64K subranges
// - Next 256K: two registers, 16K subranges
// - Top 256K: eight registers, 4K subranges
module fixed_range_memory_type_map #(
	parameter int ADDR_W = 52                    // Physical address width
) (
	input  wire logic              CLK,              // Core clock
	input  wire logic              RST,              // Synchronous reset, active high
	input  wire logic              MSR_RD,           // Model register read strobe
	input  wire logic              MSR_WR,           // Model register write strobe
	input  wire logic       [31:0] MSR_INDEX,        // Model register index
	input  wire logic       [63:0] MSR_WDATA,        // Write data
	output logic            [63:0] MSR_RDATA,        // Read data
	output logic                   MSR_ACK,          // Access done
	output logic                   MSR_FAULT,        // Index not held here
	input  wire logic              RANGE_ENABLE,     // Typing mechanism on
	input  wire logic              FIXED_ENABLE,     // Fixed ranges on
	input  wire logic              EXT_ENABLE,       // Extended fixed encoding on
	input  wire logic        [7:0] DEFAULT_TYPE,     // Software default type
	input  wire logic              VAR_HIT,          // A variable range covers address
	input  wire logic        [7:0] VAR_TYPE,         // Type of that variable range
	input  wire logic              LOOKUP_VALID,     // Lookup request
	input  wire logic [ADDR_W-1:0] LOOKUP_ADDR,      // Physical address
	output logic                   RESULT_VALID,     // Result ready
	output logic             [2:0] RESULT_TYPE,      // Resolved type code
	output logic                   RESULT_FIXED,     // Taken from a fixed field
	output logic                   RESULT_CACHEABLE, // Cacheable
	output logic                   RESULT_WC,        // Write combining allowed
	output logic                   RESULT_SPEC,      // Speculative reads allowed
	output logic                   RESULT_RD_ALLOC,  // Read miss allocates
	output logic                   RESULT_WR_ALLOC,  // Write miss allocates
	output logic                   RESULT_WR_THRU,   // Write hit updates memory
	output logic                   RESULT_HIT_INVAL, // Write hit invalidates
	output logic                   RESULT_ALLOC_MOD, // Allocate in modified state
	output logic                   RESULT_READ_MEM,  // Reads go to memory
	output logic                   RESULT_WRITE_MEM, // Writes go to memory
	output logic                   RESULT_IO         // I/O subrange
);

	localparam int N = memtype_pkg::FIXED_REG_COUNT;

	logic [63:0] fixed_reg [N];

	wire logic [31:0] index_off;
	wire logic        index_hit;
	wire logic  [3:0] index_sel;
	wire logic        wr_hit;

	// Register access: index decode against the consecutive block of fixed registers
	assign index_off = MSR_INDEX - memtype_pkg::INDEX_FIXED_BASE;
	assign index_hit = index_off < 32'(N);
	assign index_sel = index_off[3:0];
	assign wr_hit    = MSR_WR & index_hit;

	// Storage of all eleven registers; reserved bits are kept as written
	always_ff @(posedge CLK) begin
		if (RST) begin
			for (int i = 0; i < N; i++) begin
				fixed_reg[i] <= memtype_pkg::FIXED_RESET;
			end
		end else if (wr_hit) begin
			fixed_reg[index_sel] <= MSR_WDATA;
		end
	end

	// Read answers one cycle later; a read beside a write returns the old value
	always_ff @(posedge CLK) begin
		if (RST) begin
			MSR_RDATA <= memtype_pkg::READ_IDLE;
			MSR_ACK   <= 1'b0;
			MSR_FAULT <= 1'b0;
		end else begin
			MSR_ACK   <= MSR_RD | MSR_WR;
			MSR_FAULT <= (MSR_RD | MSR_WR) & ~index_hit;
			if (MSR_RD & index_hit) begin
				MSR_RDATA <= fixed_reg[index_sel];
			end else begin
				MSR_RDATA <= memtype_pkg::READ_IDLE;
			end
		end
	end

	wire logic       below_1m;
	wire logic       seg_64k;
	wire logic       seg_16k;
	wire logic [3:0] sel_reg;
	wire logic [2:0] sel_field;
	wire logic [5:0] field_lsb;
	wire logic [7:0] fixed_field;

	// Segment decode of the lowest megabyte
	assign below_1m = LOOKUP_ADDR[ADDR_W-1:memtype_pkg::ONE_MEG_BIT] == '0;
	assign seg_64k  = ~LOOKUP_ADDR[memtype_pkg::SEG_TOP_BIT];
	assign seg_16k  = LOOKUP_ADDR[memtype_pkg::SEG_TOP_BIT]
		& ~LOOKUP_ADDR[memtype_pkg::SEG_NEXT_BIT];

	// Register pick: one for 64K, two for 16K, eight for 4K subranges
	assign sel_reg = seg_64k ? memtype_pkg::REG_64K_FIRST
		: seg_16k ? memtype_pkg::REG_16K_FIRST
			+ {3'h0, LOOKUP_ADDR[memtype_pkg::SEG_16K_SHIFT+3]}
		: memtype_pkg::REG_4K_FIRST
			+ {1'b0, LOOKUP_ADDR[memtype_pkg::SEG_4K_SHIFT+5:memtype_pkg::SEG_4K_SHIFT+3]};

	// Field pick: three address bits just above the subrange size
	assign sel_field = seg_64k
		? LOOKUP_ADDR[memtype_pkg::SEG_64K_SHIFT+2:memtype_pkg::SEG_64K_SHIFT]
		: seg_16k
		? LOOKUP_ADDR[memtype_pkg::SEG_16K_SHIFT+2:memtype_pkg::SEG_16K_SHIFT]
		: LOOKUP_ADDR[memtype_pkg::SEG_4K_SHIFT+2:memtype_pkg::SEG_4K_SHIFT];

	// Field k sits at bits 8k+7..8k, so field 0 is the lowest subrange
	assign field_lsb   = {sel_field, 3'h0};
	assign fixed_field = fixed_reg[sel_reg][field_lsb +: memtype_pkg::FIELD_W];

	wire logic       use_fixed;
	wire logic [7:0] chosen_field;
	wire logic       ext_active;

	// Priority: fixed field, then variable range, then software default
	assign use_fixed    = RANGE_ENABLE & FIXED_ENABLE & below_1m;
	assign chosen_field = use_fixed ? fixed_field
		: VAR_HIT ? VAR_TYPE
		: DEFAULT_TYPE;

	// Variable and default fields never take the extended meaning
	assign ext_active = use_fixed & EXT_ENABLE;

	wire logic [2:0] d_type;
	wire logic       d_cache;
	wire logic       d_wc;
	wire logic       d_spec;
	wire logic       d_rd_alloc;
	wire logic       d_wr_alloc;
	wire logic       d_wr_thru;
	wire logic       d_hit_inval;
	wire logic       d_alloc_mod;
	wire logic       d_read_mem;
	wire logic       d_write_mem;
	wire logic       d_io;

	// Attribute decode shared by all three sources
	memtype_attr_decode u_decode (
		.FIELD          (chosen_field),
		.EXT_ACTIVE     (ext_active),
		.FORCE_UC       (~RANGE_ENABLE),
		.MEM_TYPE       (d_type),
		.CACHEABLE      (d_cache),
		.WRITE_COMBINE  (d_wc),
		.SPECULATIVE    (d_spec),
		.READ_ALLOC     (d_rd_alloc),
		.WRITE_ALLOC    (d_wr_alloc),
		.WRITE_THROUGH  (d_wr_thru),
		.HIT_INVALIDATE (d_hit_inval),
		.ALLOC_MODIFIED (d_alloc_mod),
		.READ_TO_MEM    (d_read_mem),
		.WRITE_TO_MEM   (d_write_mem),
		.IO_RANGE       (d_io)
	);

	// Result valid strobe follows each request by one cycle
	always_ff @(posedge CLK) begin
		if (RST) begin
			RESULT_VALID <= 1'b0;
		end else begin
			RESULT_VALID <= LOOKUP_VALID;
		end
	end

	// Result register; reset to uncacheable so nothing caches before programming
	always_ff @(posedge CLK) begin
		if (RST) begin
			RESULT_TYPE      <= memtype_pkg::TYPE_UC;
			RESULT_FIXED     <= 1'b0;
			RESULT_CACHEABLE <= 1'b0;
			RESULT_WC        <= 1'b0;
			RESULT_SPEC      <= 1'b0;
			RESULT_RD_ALLOC  <= 1'b0;
			RESULT_WR_ALLOC  <= 1'b0;
			RESULT_WR_THRU   <= 1'b0;
			RESULT_HIT_INVAL <= 1'b0;
			RESULT_ALLOC_MOD <= 1'b0;
			RESULT_READ_MEM  <= 1'b1;
			RESULT_WRITE_MEM <= 1'b1;
			RESULT_IO        <= 1'b0;
		end else if (LOOKUP_VALID) begin
			RESULT_TYPE      <= d_type;
			RESULT_FIXED     <= use_fixed;
			RESULT_CACHEABLE <= d_cache;
			RESULT_WC        <= d_wc;
			RESULT_SPEC      <= d_spec;
			RESULT_RD_ALLOC  <= d_rd_alloc;
			RESULT_WR_ALLOC  <= d_wr_alloc;
			RESULT_WR_THRU   <= d_wr_thru;
			RESULT_HIT_INVAL <= d_hit_inval;
			RESULT_ALLOC_MOD <= d_alloc_mod;
			RESULT_READ_MEM  <= d_read_mem;
			RESULT_WRITE_MEM <= d_write_mem;
			RESULT_IO        <= d_io;
		end
	end

endmodule

/* verification/memtype_map_chk.sv */
`timescale 1ns/1ps
module memtype_map_chk #(
	parameter int ADDR_W = 52 // Address width
) (
	input wire logic              CLK,              // Clock
	input wire logic              RST,              // Reset
	input wire logic              MSR_RD,           // Read
	input wire logic              MSR_WR,           // Write
	input wire logic       [31:0] MSR_INDEX,        // Index
	input wire logic              MSR_ACK,          // Ack
	input wire logic              MSR_FAULT,        // Fault
	input wire logic              RANGE_ENABLE,     // Typing on
	input wire logic              VAR_HIT,          // Variable hit
	input wire logic              LOOKUP_VALID,     // Lookup
	input wire logic [ADDR_W-1:0] LOOKUP_ADDR,      // Address
	input wire logic              RESULT_VALID,     // Result
	input wire logic        [2:0] RESULT_TYPE,      // Type
	input wire logic              RESULT_FIXED,     // Fixed
	input wire logic              RESULT_CACHEABLE, // Cacheable
	input wire logic              RESULT_WC,        // Combining
	input wire logic              RESULT_SPEC,      // Speculative
	input wire logic              RESULT_RD_ALLOC,  // Read alloc
	input wire logic              RESULT_WR_ALLOC,  // Write alloc
	input wire logic              RESULT_WR_THRU,   // Write through
	input wire logic              RESULT_HIT_INVAL, // Hit invalidate
	input wire logic              RESULT_ALLOC_MOD, // Modified alloc
	input wire logic              RESULT_READ_MEM,  // Read memory
	input wire logic              RESULT_WRITE_MEM  // Write memory
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// Register port timing and decode of unmapped indices
	ack_after_strobe_a: assert property ((MSR_RD || MSR_WR) |=> MSR_ACK)
		else $error("no ack after strobe");
	ack_has_cause_a: assert property (MSR_ACK |-> $past(MSR_RD || MSR_WR))
		else $error("ack without strobe");
	fault_unmapped_a: assert property ((MSR_RD || MSR_WR) && (MSR_INDEX < 32'h0000_0100 ||
		MSR_INDEX > 32'h0000_010A) |=> MSR_FAULT) else $error("unmapped index not refused");
	// Lookup answer timing and type decode, one clause per type
	result_one_cycle_a: assert property (LOOKUP_VALID |=> RESULT_VALID)
		else $error("no result after lookup");
	off_forces_uc_a: assert property (LOOKUP_VALID && !RANGE_ENABLE |=>
		RESULT_TYPE == 3'h0 && !RESULT_CACHEABLE) else $error("disabled typing not uncacheable");
	uc_no_spec_a: assert property (RESULT_VALID && RESULT_TYPE == 3'h0 |->
		!RESULT_WC && !RESULT_SPEC && !RESULT_CACHEABLE) else $error("uncacheable flags wrong");
	wc_merge_a: assert property (RESULT_VALID && RESULT_TYPE == 3'h1 |->
		RESULT_WC && RESULT_SPEC && !RESULT_CACHEABLE) else $error("combining flags wrong");
	wt_update_a: assert property (RESULT_VALID && RESULT_TYPE == 3'h4 |->
		RESULT_RD_ALLOC && !RESULT_WR_ALLOC && RESULT_WR_THRU) else $error("writethrough wrong");
	wp_invalidate_a: assert property (RESULT_VALID && RESULT_TYPE == 3'h5 |->
		RESULT_HIT_INVAL && RESULT_RD_ALLOC && !RESULT_WR_ALLOC) else $error("protect wrong");
	wb_modified_a: assert property (RESULT_VALID && RESULT_TYPE == 3'h6 |->
		RESULT_ALLOC_MOD && RESULT_WR_ALLOC) else $error("writeback flags wrong");
	var_standard_a: assert property (LOOKUP_VALID && RANGE_ENABLE && VAR_HIT &&
		LOOKUP_ADDR[ADDR_W-1:20] != '0 |=> !RESULT_FIXED && RESULT_READ_MEM && RESULT_WRITE_MEM)
		else $error("variable range not standard");
endmodule
bind fixed_range_memory_type_map memtype_map_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

/* verification/mem_access_model.sv */
`timescale 1ns/1ps
// Cache pipeline side: asks for types and keeps the latest answer
module mem_access_model (
	input  wire logic        CLK,          // Clock
	output logic             lookup_valid, // Request
	output logic      [51:0] lookup_addr,  // Address
	input  wire logic        result_valid, // Answer
	input  wire logic  [2:0] result_type,  // Type
	output logic       [2:0] last_type     // Kept type
);
	initial begin
		lookup_valid = 1'b0;
		lookup_addr  = '0;
	end
	// The valid strobe stays up for as long as requests continue, so catch it at each edge
	always @(posedge CLK) begin
		if (result_valid) begin
			last_type <= result_type;
		end
	end
	task automatic ask(input logic [51:0] a);
		lookup_valid = 1'b1;
		lookup_addr  = a;
	endtask
	// A released address is inverted so no stale value looks valid
	task automatic stop();
		lookup_valid = 1'b0;
		lookup_addr  = ~lookup_addr;
	endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
	logic        CLK, RST, MSR_RD, MSR_WR, MSR_ACK, MSR_FAULT, RESULT_IO, RESULT_WC;
	logic        RANGE_ENABLE, FIXED_ENABLE, EXT_ENABLE, VAR_HIT, LOOKUP_VALID, RESULT_VALID;
	logic        RESULT_FIXED, RESULT_CACHEABLE, RESULT_SPEC, RESULT_RD_ALLOC, RESULT_WR_ALLOC;
	logic        RESULT_WR_THRU, RESULT_HIT_INVAL, RESULT_ALLOC_MOD, RESULT_READ_MEM;
	logic        RESULT_WRITE_MEM;
	logic [2:0]  RESULT_TYPE, kept;
	logic [6:0]  last_exp;
	logic [7:0]  pol;
	logic [7:0]  DEFAULT_TYPE, VAR_TYPE;
	logic [31:0] MSR_INDEX;
	logic [63:0] MSR_WDATA, MSR_RDATA;
	logic [51:0] LOOKUP_ADDR;
	logic [63:0] regs [11];
	int          errors, cmp_count;
	fixed_range_memory_type_map dut (.*);
	mem_access_model pm (.CLK(CLK), .lookup_valid(LOOKUP_VALID), .lookup_addr(LOOKUP_ADDR),
		.result_valid(RESULT_VALID), .result_type(RESULT_TYPE), .last_type(kept));
	// Policy flags gathered in one word, highest bit cacheable
	assign pol = {RESULT_CACHEABLE, RESULT_WC, RESULT_SPEC, RESULT_RD_ALLOC, RESULT_WR_ALLOC,
		RESULT_WR_THRU, RESULT_HIT_INVAL, RESULT_ALLOC_MOD};
	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Strobe stays up for the next access; the answer stands one cycle only
	task automatic model_specific_register(input logic wr, input logic [31:0] idx, input logic [63:0] d);
		logic hit;
		hit = idx >= 32'h0000_0100 && idx <= 32'h0000_010A;
		MSR_WR = wr;
		MSR_RD = !wr;
		MSR_INDEX = idx;
		MSR_WDATA = d;
		@(negedge CLK);
		chk("ack", MSR_ACK, 64'h1);
		chk("fault", MSR_FAULT, {63'h0, !hit});
		chk("rdata", MSR_RDATA, (!wr && hit) ? regs[idx[3:0]] : 64'h0);
		if (wr && hit) regs[idx[3:0]] = d;
	endtask
	// Hold reset two cycles; afterwards every output must show its idle value
	task automatic reset_pulse();
		RST = 1'b1;
		repeat (2) @(negedge CLK);
		RST = 1'b0;
		foreach (regs[i]) regs[i] = 64'h0;
		chk("reset outputs", {RESULT_VALID, MSR_ACK, MSR_FAULT, pol, RESULT_IO,
			RESULT_READ_MEM, RESULT_WRITE_MEM, RESULT_FIXED, RESULT_TYPE}, 64'h30);
		chk("reset rdata", MSR_RDATA, 64'h0);
	endtask
	// Flags per type: cache, combine, spec, rd alloc, wr alloc, thru, inval, modified
	function automatic logic [7:0] policy(input logic [2:0] t);
		case (t)
			3'h1: return 8'h60;
			3'h4: return 8'hB4;
			3'h5: return 8'hB6;
			3'h6: return 8'hB9;
			default: return 8'h00;
		endcase
	endfunction
	// Reference resolution: off, fixed field, variable range, default
	function automatic logic [6:0] expect_res(input logic [51:0] a);
		logic [7:0] f;
		logic       fx;
		logic [3:0] r;
		int         k;
		fx = FIXED_ENABLE && a[51:20] == '0;
		r = !a[19] ? 4'h0 : !a[18] ? 4'(a[17]) + 4'h1 : 4'(a[17:15]) + 4'h3;
		k = !a[19] ? int'(a[18:16]) : !a[18] ? int'(a[16:14]) : int'(a[14:12]);
		f = fx ? regs[r][k*8 +: 8] : VAR_HIT ? VAR_TYPE : DEFAULT_TYPE;
		if (!RANGE_ENABLE) fx = 1'b0;
		if (!RANGE_ENABLE) f = 8'h00;
		if (f[2:0] inside {3'h2, 3'h3, 3'h7}) f[2:0] = 3'h0;
		if (!(fx && EXT_ENABLE)) f[4:3] = 2'b11;
		return {~&f[4:3], f[4], f[3], fx, f[2:0]};
	endfunction
	task automatic look(input logic [51:0] a);
		logic [6:0] e;
		e = expect_res(a);
		pm.ask(a);
		@(negedge CLK);
		chk("result valid", RESULT_VALID, 64'h1);
		chk("result", {RESULT_IO, RESULT_READ_MEM, RESULT_WRITE_MEM, RESULT_FIXED, RESULT_TYPE}, e);
		chk("policy", pol, 64'(policy(e[2:0])));
		last_exp = e;
	endtask
	initial begin
		#(100000 * 100);
		errors++;
		summarize();
	end
	initial begin
		void'($urandom(67123));
		{MSR_RD, MSR_WR, MSR_INDEX, MSR_WDATA} = '0;
		{RANGE_ENABLE, FIXED_ENABLE, EXT_ENABLE, VAR_HIT, VAR_TYPE, DEFAULT_TYPE} = '0;
		errors = 0;
		cmp_count = 0;
		foreach (regs[i]) regs[i] = 64'h0;
		reset_pulse();
		// Reset contents, random fill, read back in reverse, unmapped indices
		for (int i = 0; i < 11; i++) model_specific_register(1'b0, 32'h0000_0100 + i, 64'h0);
		for (int i = 0; i < 11; i++) model_specific_register(1'b1, 32'h0000_0100 + i, {$urandom, $urandom});
		for (int i = 10; i >= 0; i--) model_specific_register(1'b0, 32'h0000_0100 + i, 64'h0);
		// Read and write in one cycle: old word comes back, new word is stored
		{MSR_RD, MSR_WR, MSR_INDEX, MSR_WDATA} = {2'b11, 32'h0000_0105, 64'h0123_4567_89AB_CDEF};
		@(negedge CLK);
		chk("rdwr old", MSR_RDATA, regs[5]);
		regs[5] = 64'h0123_4567_89AB_CDEF;
		model_specific_register(1'b0, 32'h0000_0105, 64'h0);
		for (int i = 0; i < 4; i++) model_specific_register(i[0], i[1] ? 32'h0000_010B : 32'h0000_00FF, '1);
		MSR_WR = 1'b0;
		MSR_RD = 1'b0;
		// Segment edges back to back, then random traffic and controls
		RANGE_ENABLE = 1'b1;
		FIXED_ENABLE = 1'b1;
		foreach (regs[i]) look({32'h0, 20'h80000 + 20'(i) * 20'h08000 - 20'h1});
		look(52'h0_0000);
		look(52'h7_FFFF);
		look(52'hF_FFFF);
		look(52'h10_0000);
		repeat (400) begin
			RANGE_ENABLE = ($urandom % 4) != 0;
			{FIXED_ENABLE, EXT_ENABLE, VAR_HIT} = 3'($urandom);
			VAR_TYPE = 8'($urandom);
			DEFAULT_TYPE = 8'($urandom);
			look(($urandom % 4 == 0) ? 52'({$urandom, $urandom}) : 52'($urandom % 32'h0010_0000));
		end
		pm.stop();
		@(negedge CLK);
		chk("valid drop", RESULT_VALID, 64'h0);
		chk("held type", RESULT_TYPE, 64'(last_exp[2:0]));
		chk("pipeline type", kept, 64'(last_exp[2:0]));
		// Reset in mid-run clears the registers and the held result
		reset_pulse();
		model_specific_register(1'b0, 32'h0000_0105, 64'h0);
		summarize();
	end
endmodule
